/* rtl/bbcc_pkg.sv */
// package for the backlight boost and sink current configuration block
// assumes a single 200 MHz clock domain and word-aligned AHB-Lite access
package bbcc_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0]  BBCC_IDX_SPAN_TRIM   = 8'h9E;
   localparam logic [7:0]  BBCC_IDX_CUR_LOW     = 8'hA0;
   localparam logic [7:0]  BBCC_IDX_CUR_HIGH    = 8'hA1;
   localparam logic [7:0]  BBCC_IDX_SINK_CTRL   = 8'hC0;
   localparam logic [7:0]  BBCC_IDX_STATUS      = 8'hC1;
   localparam int          BBCC_WORD_SHIFT      = 2;
   localparam int          BBCC_IDX_W           = 8;

   // reset values
   localparam logic [7:0]  BBCC_RST_SPAN_TRIM   = 8'h00;
   localparam logic [7:0]  BBCC_RST_CUR_LOW     = 8'h00;
   localparam logic [7:0]  BBCC_RST_CUR_HIGH    = 8'h00;
   localparam logic [7:0]  BBCC_RST_SINK_CTRL   = 8'h00;

   // field positions
   localparam int          BBCC_SPAN_BIT        = 5;
   localparam int          BBCC_TRIM_LSB        = 0;
   localparam int          BBCC_TRIM_W          = 4;
   localparam int          BBCC_NIB_LSB         = 0;
   localparam int          BBCC_NIB_W           = 4;
   localparam int          BBCC_PEAK_LSB        = 4;
   localparam int          BBCC_PEAK_W          = 3;
   localparam int          BBCC_EXT_BIT         = 0;
   localparam int          BBCC_BASE_LSB        = 1;
   localparam int          BBCC_BASE_W          = 3;
   localparam int          BBCC_CODE_W          = 12;
   localparam int          BBCC_MV_W            = 16;
   localparam int          BBCC_UA_W            = 16;

   // boost spans in mV
   localparam logic [15:0] BBCC_SPAN_LO_MIN_MV  = 16'd7000;
   localparam logic [15:0] BBCC_SPAN_LO_MAX_MV  = 16'd34000;
   localparam logic [15:0] BBCC_SPAN_HI_MIN_MV  = 16'd16000;
   localparam logic [15:0] BBCC_SPAN_HI_MAX_MV  = 16'd43000;

   // headroom offsets in mV
   localparam logic [15:0] BBCC_MARGIN_0_MV     = 16'd460;
   localparam logic [15:0] BBCC_MARGIN_1_MV     = 16'd390;
   localparam logic [15:0] BBCC_MARGIN_2_MV     = 16'd320;
   localparam logic [15:0] BBCC_MARGIN_4_MV     = 16'd250;
   localparam logic [15:0] BBCC_MARGIN_8_MV     = 16'd180;

   localparam logic [11:0] BBCC_CODE_FULL       = 12'hFFF;
   localparam logic [1:0]  BBCC_HTRANS_NONSEQ   = 2'h2;
   localparam logic [1:0]  BBCC_HTRANS_SEQ      = 2'h3;
endpackage : bbcc_pkg

/* rtl/bbcc_current_scale.sv */
// sink current scaler: code/4095 of the selected peak level
// assumes code and select come from flip-flops on the same clock
`timescale 1ns/1ps
module bbcc_current_scale
   import bbcc_pkg::*;
#(
   parameter int PEAK_STEP_UA = 6250
) (
   input  wire logic                    i_clk,
   input  wire logic                    i_rst,
   input  wire logic [BBCC_CODE_W-1:0]  i_code,
   input  wire logic [BBCC_PEAK_W-1:0]  i_peak_sel,
   output logic      [BBCC_UA_W-1:0]    o_peak_ua,
   output logic      [BBCC_UA_W-1:0]    o_sink_ua
);
   logic [31:0] peak_w;
   logic [31:0] prod_w;

   // peak level steps evenly, top select gives eight steps
   assign peak_w = (32'(i_peak_sel) + 32'd1) * 32'(PEAK_STEP_UA);
   // exact zero at code 0 and exact peak at full code
   assign prod_w = (peak_w * 32'(i_code)) / 32'(BBCC_CODE_FULL);

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_peak_ua <= '0;
         o_sink_ua <= '0;
      end else begin
         o_peak_ua <= peak_w[BBCC_UA_W-1:0];
         o_sink_ua <= prod_w[BBCC_UA_W-1:0];
      end
   end
endmodule : bbcc_current_scale

/* rtl/bbcc_top.sv */
// boost span, headroom trim and LED sink current configuration registers
// assumes one AHB-Lite master, word transfers only, single clock domain
//
// Functional notes
// - span select clear gives 7-34 V boost, set gives 16-43 V.
// - 4-bit trim picks headroom 460, 390, 320, 250 or 180 mV.
// - low threshold from trim plus margin base; trim also feeds mid threshold.
// - 12-bit current code: low byte gives bits 7:0.
// - sink current is code/4095 of peak; zero gives zero, full gives peak.
// - resistor select set adds scaling by external set resistor.
// - neighbouring register bits 3:0 give code bits 11:8.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
module bbcc_top
   import bbcc_pkg::*;
#(
   parameter int PEAK_STEP_UA  = 6250,
   parameter int BASE_STEP_MV  = 50,
   parameter int MID_EXTRA_MV  = 300
) (
   input  wire logic                   i_clk,
   input  wire logic                   i_rst,
   input  wire logic                   i_hsel,
   input  wire logic [31:0]            i_haddr,
   input  wire logic [1:0]             i_htrans,
   input  wire logic                   i_hwrite,
   input  wire logic [2:0]             i_hsize,
   input  wire logic [31:0]            i_hwdata,
   input  wire logic                   i_hready,
   output logic                        o_hreadyout,
   output logic                        o_hresp,
   output logic      [31:0]            o_hrdata,
   output logic                        o_boost_span_high,
   output logic      [BBCC_MV_W-1:0]   o_boost_min_mv,
   output logic      [BBCC_MV_W-1:0]   o_boost_max_mv,
   output logic      [BBCC_MV_W-1:0]   o_margin_mv,
   output logic      [BBCC_MV_W-1:0]   o_low_thr_mv,
   output logic      [BBCC_MV_W-1:0]   o_mid_thr_mv,
   output logic      [BBCC_CODE_W-1:0] o_sink_code,
   output logic      [BBCC_UA_W-1:0]   o_peak_ua,
   output logic      [BBCC_UA_W-1:0]   o_sink_ua,
   output logic                        o_use_set_resistor
);
   ////////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [BBCC_MV_W-1:0] margin_of(input logic [3:0] trim);
      logic [BBCC_MV_W-1:0] mv;
      mv = BBCC_MARGIN_0_MV;
      // unlisted codes follow their highest set bit, keeping the map monotonic
      casez (trim)
         4'b1???: mv = BBCC_MARGIN_8_MV;
         4'b01??: mv = BBCC_MARGIN_4_MV;
         4'b001?: mv = BBCC_MARGIN_2_MV;
         4'b0001: mv = BBCC_MARGIN_1_MV;
         default: mv = BBCC_MARGIN_0_MV;
      endcase
      return mv;
   endfunction : margin_of

   function automatic logic [BBCC_IDX_W-1:0] idx_of(input logic [31:0] a);
      return a[BBCC_IDX_W+BBCC_WORD_SHIFT-1:BBCC_WORD_SHIFT];
   endfunction : idx_of

   function automatic logic mapped(input logic [31:0] a);
      return (a[31:BBCC_IDX_W+BBCC_WORD_SHIFT] == '0) && (a[1:0] == 2'h0);
   endfunction : mapped

   ////////////////////////////////////////////////////////////////////////////////
   // bus address phase
   logic                  acc_w;
   logic                  wr_pend_r;
   logic [BBCC_IDX_W-1:0] wr_idx_r;
   logic [7:0]            span_trim_r;
   logic [7:0]            cur_low_r;
   logic [7:0]            cur_high_r;
   logic [7:0]            sink_ctrl_r;
   logic [31:0]           status_w;
   logic [7:0]            fwd_span;
   logic [7:0]            fwd_low;
   logic [7:0]            fwd_high;
   logic [7:0]            fwd_ctrl;

   assign acc_w = i_hsel && i_hready && i_htrans[1];
   // zero wait states, always OKAY
   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_pend_r <= 1'b0;
         wr_idx_r  <= '0;
      end else begin
         wr_pend_r <= acc_w && i_hwrite && mapped(i_haddr);
         wr_idx_r  <= idx_of(i_haddr);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register writes in the data phase
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         span_trim_r <= BBCC_RST_SPAN_TRIM;
         cur_low_r   <= BBCC_RST_CUR_LOW;
         cur_high_r  <= BBCC_RST_CUR_HIGH;
         sink_ctrl_r <= BBCC_RST_SINK_CTRL;
      end else if (wr_pend_r) begin
         unique case (wr_idx_r)
            BBCC_IDX_SPAN_TRIM: span_trim_r <= i_hwdata[7:0];
            BBCC_IDX_CUR_LOW:   cur_low_r   <= i_hwdata[7:0];
            BBCC_IDX_CUR_HIGH:  cur_high_r  <= i_hwdata[7:0];
            BBCC_IDX_SINK_CTRL: sink_ctrl_r <= i_hwdata[7:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read data; a write still in its data phase is forwarded so a
   // back-to-back read of the same word never sees the stale value
   assign fwd_span = (wr_pend_r && wr_idx_r == BBCC_IDX_SPAN_TRIM) ? i_hwdata[7:0] : span_trim_r;
   assign fwd_low  = (wr_pend_r && wr_idx_r == BBCC_IDX_CUR_LOW)   ? i_hwdata[7:0] : cur_low_r;
   assign fwd_high = (wr_pend_r && wr_idx_r == BBCC_IDX_CUR_HIGH)  ? i_hwdata[7:0] : cur_high_r;
   assign fwd_ctrl = (wr_pend_r && wr_idx_r == BBCC_IDX_SINK_CTRL) ? i_hwdata[7:0] : sink_ctrl_r;
   // status shows settled code and span as the sink sees them
   assign status_w = {19'h0, o_boost_span_high, o_sink_code};

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_hrdata <= '0;
      end else if (acc_w && !i_hwrite) begin
         o_hrdata <= '0; // unmapped reads return zero
         if (mapped(i_haddr)) begin
            unique case (idx_of(i_haddr))
               BBCC_IDX_SPAN_TRIM: o_hrdata <= {24'h0, fwd_span};
               BBCC_IDX_CUR_LOW:   o_hrdata <= {24'h0, fwd_low};
               BBCC_IDX_CUR_HIGH:  o_hrdata <= {24'h0, fwd_high};
               BBCC_IDX_SINK_CTRL: o_hrdata <= {24'h0, fwd_ctrl};
               BBCC_IDX_STATUS:    o_hrdata <= status_w;
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // boost span and comparator thresholds
   logic [3:0]           trim_w;
   logic [2:0]           base_w;
   logic [BBCC_MV_W-1:0] margin_w;

   assign trim_w   = span_trim_r[BBCC_TRIM_LSB +: BBCC_TRIM_W];
   assign base_w   = sink_ctrl_r[BBCC_BASE_LSB +: BBCC_BASE_W];
   assign margin_w = margin_of(trim_w);

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_boost_span_high <= 1'b0;
         o_boost_min_mv    <= BBCC_SPAN_LO_MIN_MV;
         o_boost_max_mv    <= BBCC_SPAN_LO_MAX_MV;
      end else begin
         o_boost_span_high <= span_trim_r[BBCC_SPAN_BIT];
         o_boost_min_mv    <= span_trim_r[BBCC_SPAN_BIT] ? BBCC_SPAN_HI_MIN_MV
                                                         : BBCC_SPAN_LO_MIN_MV;
         o_boost_max_mv    <= span_trim_r[BBCC_SPAN_BIT] ? BBCC_SPAN_HI_MAX_MV
                                                         : BBCC_SPAN_LO_MAX_MV;
      end
   end

   // thresholds in mV; base adds whole steps on top of the trim for the low threshold only
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_margin_mv  <= BBCC_MARGIN_0_MV;
         o_low_thr_mv <= BBCC_MARGIN_0_MV;
         o_mid_thr_mv <= BBCC_MARGIN_0_MV;
      end else begin
         o_margin_mv  <= margin_w;
         o_low_thr_mv <= margin_w + BBCC_MV_W'(32'(base_w) * 32'(BASE_STEP_MV));
         o_mid_thr_mv <= margin_w + BBCC_MV_W'(MID_EXTRA_MV);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sink current code and scaling
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_sink_code        <= '0;
         o_use_set_resistor <= 1'b0;
      end else begin
         o_sink_code        <= {cur_high_r[BBCC_NIB_LSB +: BBCC_NIB_W], cur_low_r};
         o_use_set_resistor <= sink_ctrl_r[BBCC_EXT_BIT];
      end
   end

   // resistor scaling is analog; the digital code stays the same either way
   bbcc_current_scale #(
      .PEAK_STEP_UA (PEAK_STEP_UA)
   ) u_scale (
      .i_clk      (i_clk),
      .i_rst      (i_rst),
      .i_code     (o_sink_code),
      .i_peak_sel (cur_high_r[BBCC_PEAK_LSB +: BBCC_PEAK_W]),
      .o_peak_ua  (o_peak_ua),
      .o_sink_ua  (o_sink_ua)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // assertions
   sequence s_wr_span_hi;
      acc_w && i_hwrite && mapped(i_haddr) && idx_of(i_haddr) == BBCC_IDX_SPAN_TRIM
      ##1 i_hwdata[BBCC_SPAN_BIT];
   endsequence

   sequence s_wr_ext_on;
      acc_w && i_hwrite && mapped(i_haddr) && idx_of(i_haddr) == BBCC_IDX_SINK_CTRL
      ##1 i_hwdata[BBCC_EXT_BIT];
   endsequence

   property p_span_high;
      @(posedge i_clk) disable iff (i_rst)
      s_wr_span_hi |-> ##2 (o_boost_min_mv == BBCC_SPAN_HI_MIN_MV
                            && o_boost_max_mv == BBCC_SPAN_HI_MAX_MV);
   endproperty
   a_span_high: assert property (p_span_high) else $error("span high not applied");

   property p_span_low;
      @(posedge i_clk) disable iff (i_rst)
      !span_trim_r[BBCC_SPAN_BIT] |=> (o_boost_min_mv == BBCC_SPAN_LO_MIN_MV
                                       && o_boost_max_mv == BBCC_SPAN_LO_MAX_MV);
   endproperty
   a_span_low: assert property (p_span_low) else $error("span low wrong");

   property p_margin_zero;
      @(posedge i_clk) disable iff (i_rst)
      trim_w == 4'h0 |=> o_margin_mv == BBCC_MARGIN_0_MV;
   endproperty
   a_margin_zero: assert property (p_margin_zero) else $error("trim 0 not 460 mV");

   property p_margin_steps;
      @(posedge i_clk) disable iff (i_rst)
      (trim_w == 4'h8 |=> o_margin_mv == BBCC_MARGIN_8_MV)
      and (trim_w == 4'h4 |=> o_margin_mv == BBCC_MARGIN_4_MV)
      and (trim_w == 4'h2 |=> o_margin_mv == BBCC_MARGIN_2_MV)
      and (trim_w == 4'h1 |=> o_margin_mv == BBCC_MARGIN_1_MV);
   endproperty
   a_margin_steps: assert property (p_margin_steps) else $error("trim step wrong");

   property p_thresholds;
      @(posedge i_clk) disable iff (i_rst)
      $stable(span_trim_r) && $stable(sink_ctrl_r) |=>
         (o_low_thr_mv >= o_margin_mv) && (o_mid_thr_mv - o_margin_mv == 16'(MID_EXTRA_MV))
         // outputs lag the register by one edge, so compare with the base before it
         && (o_low_thr_mv - o_margin_mv == 16'(32'($past(base_w)) * 32'(BASE_STEP_MV)));
   endproperty
   a_thresholds: assert property (p_thresholds) else $error("threshold not from trim");

   property p_code_join;
      @(posedge i_clk) disable iff (i_rst)
      $stable(cur_low_r) && $stable(cur_high_r) |=>
         o_sink_code[7:0] == $past(cur_low_r) && o_sink_code[11:8] == $past(cur_high_r[3:0]);
   endproperty
   a_code_join: assert property (p_code_join) else $error("code halves misplaced");

   property p_zero_full;
      @(posedge i_clk) disable iff (i_rst)
      (o_sink_code == 12'h000 |=> o_sink_ua == 16'h0000)
      and (o_sink_code == BBCC_CODE_FULL && $stable(cur_high_r) |=> o_sink_ua == o_peak_ua);
   endproperty
   a_zero_full: assert property (p_zero_full) else $error("zero or full current wrong");

   property p_ext_sel;
      @(posedge i_clk) disable iff (i_rst)
      s_wr_ext_on |-> ##2 o_use_set_resistor;
   endproperty
   a_ext_sel: assert property (p_ext_sel) else $error("resistor select not applied");

   property p_high_nibble;
      @(posedge i_clk) disable iff (i_rst)
      acc_w && i_hwrite && mapped(i_haddr) && idx_of(i_haddr) == BBCC_IDX_CUR_HIGH
      ##1 1'b1 |-> ##2 o_sink_code[11:8] == $past(i_hwdata[3:0], 2);
   endproperty
   a_high_nibble: assert property (p_high_nibble) else $error("high nibble not in code");
endmodule : bbcc_top

/* tb/tb.sv */
// self-checking bench for the boost span, headroom trim and sink current registers
// assumes bbcc_pkg is compiled first; one AHB-Lite master, no wait states expected
`timescale 1ns/1ps
module tb;
   import bbcc_pkg::*;
   logic        i_clk, i_rst, hsel, hwrite;
   logic [31:0] haddr, hwdata, rdat;
   logic [1:0]  htrans;
   logic        hreadyout, hresp, span_hi, use_res;
   logic [31:0] hrdata;
   logic [15:0] min_mv, max_mv, margin_mv, low_mv, mid_mv, peak_ua, sink_ua;
   logic [11:0] code;
   int          mismatches, n_tests, st, lo, hi, ct, i, k, c, rg;
   int          trims[5] = '{0, 1, 2, 4, 8};
   int          codes[8] = '{0, 1, 2, 2047, 4093, 4094, 4095, 1234};
   logic [7:0]  idx[4];

   bbcc_top uut (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
      .o_boost_span_high(span_hi), .o_boost_min_mv(min_mv), .o_boost_max_mv(max_mv),
      .o_margin_mv(margin_mv), .o_low_thr_mv(low_mv), .o_mid_thr_mv(mid_mv),
      .o_sink_code(code), .o_peak_ua(peak_ua), .o_sink_ua(sink_ua),
      .o_use_set_resistor(use_res));

   ////////////////////////////////////////////////////////////////////////////
   // reporting
   task summarize;
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   task chk_rd(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t read %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk_rd

   task chk_pin(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t pin %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask : chk_pin

   ////////////////////////////////////////////////////////////////////////////
   // bus master; waits are bounded so a stuck slave ends the run
   task wait_rdy;
      for (k = 0; k < 20; k++) begin
         @(posedge i_clk);
         if (hreadyout === 1'b1) return;
      end
      mismatches++;
      $display("BAD t=%0t hready timeout", $time);
      summarize();
   endtask : wait_rdy

   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge i_clk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= BBCC_HTRANS_NONSEQ;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rdat = hrdata;
      chk_rd({31'h0, hresp}, 32'h0, "hresp");
   endtask : bus

   // write and mirror into the model; unmapped indices change nothing
   task wr(input logic [7:0] ix, input int d);
      bus(1'b1, {22'h0, ix, 2'h0}, d);
      case (ix)
         BBCC_IDX_SPAN_TRIM: st = d & 8'hFF;
         BBCC_IDX_CUR_LOW:   lo = d & 8'hFF;
         BBCC_IDX_CUR_HIGH:  hi = d & 8'hFF;
         BBCC_IDX_SINK_CTRL: ct = d & 8'hFF;
         default: ;
      endcase
   endtask : wr

   task rd_chk(input logic [31:0] a, input int exp, input string what);
      bus(1'b0, a, 32'h0);
      chk_rd(rdat, exp, what);
   endtask : rd_chk

   ////////////////////////////////////////////////////////////////////////////
   // model of the derived outputs; sink current settles two edges after a write, checked after four
   task check_all;
      int m, cd, pk;
      repeat (4) @(posedge i_clk);
      #1;
      m  = st[3] ? 180 : st[2] ? 250 : st[1] ? 320 : st[0] ? 390 : 460;
      cd = ((hi & 15) << 8) | lo;
      pk = (((hi >> 4) & 7) + 1) * 6250;
      chk_pin(span_hi, st[5], "span");
      chk_pin(min_mv, st[5] ? 16000 : 7000, "boost min");
      chk_pin(max_mv, st[5] ? 43000 : 34000, "boost max");
      chk_pin(margin_mv, m, "margin");
      chk_pin(low_mv, m + ((ct >> 1) & 7) * 50, "low thr");
      chk_pin(mid_mv, m + 300, "mid thr");
      chk_pin(code, cd, "code");
      chk_pin(peak_ua, pk, "peak");
      chk_pin(sink_ua, (cd * pk) / 4095, "sink");
      chk_pin(use_res, ct & 1, "resistor sel");
      rd_chk(BBCC_IDX_STATUS << 2, cd | (st[5] << 12), "status");
      rd_chk(BBCC_IDX_SPAN_TRIM << 2, st, "span/trim");
      rd_chk(BBCC_IDX_CUR_LOW << 2, lo, "low byte");
      rd_chk(BBCC_IDX_CUR_HIGH << 2, hi, "high nibble");
      rd_chk(BBCC_IDX_SINK_CTRL << 2, ct, "sink ctrl");
   endtask : check_all

   ////////////////////////////////////////////////////////////////////////////
   // clock at 200 MHz
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   // main sequence
   initial begin
      i_rst = 1'b1; hsel = 1'b0; haddr = 32'h0; hwrite = 1'b0;
      htrans = 2'h0; hwdata = 32'h0;
      st = 0; lo = 0; hi = 0; ct = 0;
      idx = '{BBCC_IDX_SPAN_TRIM, BBCC_IDX_CUR_LOW, BBCC_IDX_CUR_HIGH, BBCC_IDX_SINK_CTRL};
      void'($urandom(32'h830e990b));
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      check_all();
      $display("test reset values done");
      // every listed trim code, span bit alternating
      for (i = 0; i < 5; i++) begin
         wr(BBCC_IDX_SPAN_TRIM, trims[i] | ((i % 2) << 5));
         check_all();
      end
      // application needing 40 V: software picks the high span
      wr(BBCC_IDX_SPAN_TRIM, 32'h20 | trims[2]);
      check_all();
      chk_pin(max_mv >= 40000, 1, "span covers 40 V");
      $display("test trim and span done");
      // code boundaries across all peak selections
      for (i = 0; i < 8; i++) begin
         wr(BBCC_IDX_CUR_LOW, codes[i] & 8'hFF);
         wr(BBCC_IDX_CUR_HIGH, (i << 4) | (codes[i] >> 8));
         check_all();
      end
      $display("test code scaling done");
      // resistor select and margin base, all values
      for (i = 0; i < 16; i++) begin
         wr(BBCC_IDX_SINK_CTRL, i);
         check_all();
      end
      $display("test sink control done");
      // unmapped and misaligned places read zero and ignore writes
      wr(8'h9F, 32'hFF);
      rd_chk(32'h0000_027C, 0, "unmapped");
      bus(1'b1, 32'h0000_0279, 32'h0);
      rd_chk(32'h0000_0279, 0, "misaligned");
      check_all();
      $display("test unmapped done");
      // random traffic within the defined fields
      for (i = 0; i < 30; i++) begin
         rg = $urandom_range(3, 0);
         c  = $urandom;
         c  = c & ((rg == 0) ? 8'h2F : (rg == 1) ? 8'hFF : (rg == 2) ? 8'h7F : 8'h0F);
         wr(idx[rg], c);
         check_all();
      end
      $display("test random done");
      summarize();
   end
endmodule : tb
